// File: dbg_pkg.sv
package dbg_pkg;

  // Widths of the register ports and of one trace word, and the trace FIFO depth.
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned FIFO_DEPTH = 8;

  // Byte offsets inside the debug block's window of the memory map.
  localparam logic [ADDR_W-1:0] OFS_CMP_A_HIGH   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CMP_A_LOW    = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_CMP_B_HIGH   = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_CMP_B_LOW    = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_FIFO_HIGH    = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_FIFO_LOW     = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_FORCE_RESET  = 4'hf;

  // Field positions and fixed values.
  localparam int unsigned      FORCE_RESET_BIT  = 0;
  localparam logic [BYTE_W-1:0] BYTE_ZERO       = 8'h00;
  localparam logic [WORD_W-1:0] WORD_ZERO       = 16'h0000;
  localparam logic [BYTE_W-1:0] CMP_RESET       = 8'h00;
  localparam logic [WORD_W-1:0] BKPT_RESET      = 16'h0000;
  localparam logic [WORD_W-1:0] FIFO_RESET      = 16'h0000;

endpackage : dbg_pkg

// File: dbg_links_if.sv
`timescale 1ns/1ps
// Write strobes into one comparator value pair and the value it holds.
interface compare_if;
  import dbg_pkg::*;
  logic              wr_high;
  logic              wr_low;
  logic              armed;
  logic [BYTE_W-1:0] wdata;
  logic [WORD_W-1:0] value;
  modport owner (input wr_high, input wr_low, input armed, input wdata, output value);
  modport user  (output wr_high, output wr_low, output armed, output wdata, input value);
endinterface : compare_if

// File: compare_value_reg.sv
`timescale 1ns/1ps
module compare_value_reg
  import dbg_pkg::*;
(
  // Clock and reset
  input wire logic   clk,
  input wire logic   rst_n,
  // Register side
  compare_if.owner   cmp
);

  logic [BYTE_W-1:0] high_q;
  logic [BYTE_W-1:0] low_q;
  logic              take_high;
  logic              take_low;

  // Writes are dropped while a debug run is armed.
  assign take_high = cmp.wr_high && !cmp.armed;
  assign take_low  = cmp.wr_low && !cmp.armed;
  assign cmp.value = {high_q, low_q};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      high_q <= CMP_RESET;
      low_q  <= CMP_RESET;
    end
    else
    begin
      if (take_high)
        high_q <= cmp.wdata;
      if (take_low)
        low_q <= cmp.wdata;
    end
  end

endmodule : compare_value_reg

// File: trace_shift_fifo.sv
`timescale 1ns/1ps
module trace_shift_fifo
  import dbg_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Shift control
  input  wire logic              shift_in,
  input  wire logic [WORD_W-1:0] shift_data,
  // Oldest word
  output logic      [WORD_W-1:0] head
);

  logic [WORD_W-1:0] word_q [FIFO_DEPTH];

  assign head = word_q[0];

  // Every shift drops the oldest word and appends at the last location,
  // so a word becomes visible FIFO_DEPTH - 1 shifts after the shift that took it in.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < FIFO_DEPTH; i++)
        word_q[i] <= FIFO_RESET;
    end
    else if (shift_in)
    begin
      for (int i = 0; i < FIFO_DEPTH - 1; i++)
        word_q[i] <= word_q[i+1];
      word_q[FIFO_DEPTH-1] <= shift_data;
    end
  end

endmodule : trace_shift_fifo

// File: debug_breakpoint_fifo_regs.sv
`timescale 1ns/1ps
module debug_breakpoint_fifo_regs
  import dbg_pkg::*;
(
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RST_N,
  // CPU access to the memory-mapped debug bytes
  input  wire logic              CPU_RD,
  input  wire logic              CPU_WR,
  input  wire logic [ADDR_W-1:0] CPU_ADDR,
  input  wire logic [BYTE_W-1:0] CPU_WDATA,
  output logic      [BYTE_W-1:0] CPU_RDATA,
  // Serial background memory writes into the same window
  input  wire logic              SER_WR,
  input  wire logic [ADDR_W-1:0] SER_ADDR,
  input  wire logic [BYTE_W-1:0] SER_WDATA,
  output logic                   FORCE_RESET,
  // Serial breakpoint commands
  input  wire logic              BKPT_CMD_RD,
  input  wire logic              BKPT_CMD_WR,
  input  wire logic [WORD_W-1:0] BKPT_CMD_WDATA,
  output logic      [WORD_W-1:0] BKPT_CMD_RDATA,
  // Breakpoint configuration from the background status and control bits
  input  wire logic              BREAKPOINT_ENABLE,
  input  wire logic              FORCE_TAG_SELECT,
  // CPU address bus observation
  input  wire logic              ADDR_VALID,
  input  wire logic              OPCODE_FETCH,
  input  wire logic [WORD_W-1:0] ADDR_BUS,
  input  wire logic [WORD_W-1:0] LAST_OPCODE_ADDR,
  output logic                   BREAK_FORCE_REQ,
  output logic                   BREAK_TAG_REQ,
  // Debug control writes and run status
  input  wire logic              CTRL_WR,
  input  wire logic              CTRL_WDATA_ENABLE,
  input  wire logic              CTRL_WDATA_ARM,
  input  wire logic              RUN_DONE,
  output logic                   ARMED,
  // Trace capture from the trigger logic
  input  wire logic              EVENT_ONLY,
  input  wire logic              TRACE_PUSH,
  input  wire logic [WORD_W-1:0] TRACE_DATA,
  // Comparator values towards the trigger logic
  output logic      [WORD_W-1:0] COMPARE_A,
  output logic      [WORD_W-1:0] COMPARE_B
);

  logic              arm_q;
  logic              arm_d;
  logic [WORD_W-1:0] bkpt_q;
  logic [WORD_W-1:0] bkpt_rdata_q;
  logic [BYTE_W-1:0] rdata_q;
  logic [BYTE_W-1:0] rdata_d;
  logic              force_reset_q;
  logic              break_force_q;
  logic              break_tag_q;

  logic              any_wr;
  logic [ADDR_W-1:0] wr_addr;
  logic [BYTE_W-1:0] wr_data;
  logic              ser_hits_reset;
  logic              rd_fifo_low;
  logic              fifo_shift;
  logic [WORD_W-1:0] fifo_shift_data;
  logic [WORD_W-1:0] fifo_head;
  logic [WORD_W-1:0] capture_word;
  logic [BYTE_W-1:0] fifo_high_byte;
  logic [BYTE_W-1:0] fifo_low_byte;
  logic              bkpt_hit;
  logic              arm_set;
  logic              arm_clear;

  compare_if cmp_a ();
  compare_if cmp_b ();

  // Write steering. A serial write and a CPU write in the same cycle
  // cannot both land; the serial one wins since the host is in charge.
  assign any_wr  = CPU_WR || SER_WR;
  assign wr_addr = SER_WR ? SER_ADDR : CPU_ADDR;
  assign wr_data = SER_WR ? SER_WDATA : CPU_WDATA;

  // Serial writes reach the comparator bytes as well and are held off by arm
  // in the same way, so the host cannot alter a run in flight.
  // comparator A bytes
  assign cmp_a.wr_high = any_wr && (wr_addr == OFS_CMP_A_HIGH);
  assign cmp_a.wr_low  = any_wr && (wr_addr == OFS_CMP_A_LOW);
  assign cmp_a.wdata   = wr_data;
  assign cmp_a.armed   = arm_q;

  assign cmp_b.wr_high = any_wr && (wr_addr == OFS_CMP_B_HIGH);
  assign cmp_b.wr_low  = any_wr && (wr_addr == OFS_CMP_B_LOW);
  assign cmp_b.wdata   = wr_data;
  assign cmp_b.armed   = arm_q;

  compare_value_reg u_cmp_a (
    .clk   (CLK),
    .rst_n (RST_N),
    .cmp   (cmp_a.owner)
  );

  compare_value_reg u_cmp_b (
    .clk   (CLK),
    .rst_n (RST_N),
    .cmp   (cmp_b.owner)
  );

  assign COMPARE_A = cmp_a.value;
  assign COMPARE_B = cmp_b.value;

  assign ser_hits_reset = SER_WR && (SER_ADDR == OFS_FORCE_RESET);

  // Arm control. A set in the same cycle as a run end wins, so a fresh
  // run started just as the old one finishes is not lost.
  // arm set and clear
  assign arm_set   = CTRL_WR && CTRL_WDATA_ENABLE && CTRL_WDATA_ARM;
  assign arm_clear = RUN_DONE || (CTRL_WR && !(CTRL_WDATA_ENABLE && CTRL_WDATA_ARM));
  assign arm_d     = arm_set ? 1'b1 : (arm_clear ? 1'b0 : arm_q);
  // Software sees the very flag that gates writes and pushes, never a copy.
  assign ARMED     = arm_q;

  // Trace FIFO sequencing. Only the low byte offset is decoded, since a high
  // byte read must leave the FIFO where it is.
  assign rd_fifo_low = CPU_RD && (CPU_ADDR == OFS_FIFO_LOW);

  // event-only keeps the low byte only
  assign capture_word = EVENT_ONLY ? {BYTE_ZERO, TRACE_DATA[BYTE_W-1:0]} : TRACE_DATA;

  // While armed the trigger logic owns the FIFO, so CPU reads must not
  // disturb a capture in progress; pushes then wrap and drop the oldest word.
  // high reads hold
  assign fifo_shift      = arm_q ? TRACE_PUSH : rd_fifo_low;
  assign fifo_shift_data = arm_q ? capture_word : LAST_OPCODE_ADDR;

  trace_shift_fifo u_fifo (
    .clk        (CLK),
    .rst_n      (RST_N),
    .shift_in   (fifo_shift),
    .shift_data (fifo_shift_data),
    .head       (fifo_head)
  );

  // The high byte is masked at the read port too, so 16-bit words left over
  // from an unarmed profile also read zero once event-only capture is chosen.
  // high byte view
  assign fifo_high_byte = EVENT_ONLY ? BYTE_ZERO : fifo_head[WORD_W-1:BYTE_W];
  assign fifo_low_byte  = fifo_head[BYTE_W-1:0];

  // Read multiplexer; unused offsets and the force-reset byte read zero.
  // memory-mapped bytes
  always_comb
  begin
    rdata_d = BYTE_ZERO;
    unique case (CPU_ADDR)
      OFS_CMP_A_HIGH:  rdata_d = cmp_a.value[WORD_W-1:BYTE_W];
      OFS_CMP_A_LOW:   rdata_d = cmp_a.value[BYTE_W-1:0];
      OFS_CMP_B_HIGH:  rdata_d = cmp_b.value[WORD_W-1:BYTE_W];
      OFS_CMP_B_LOW:   rdata_d = cmp_b.value[BYTE_W-1:0];
      OFS_FIFO_HIGH:   rdata_d = fifo_high_byte;
      OFS_FIFO_LOW:    rdata_d = fifo_low_byte;
      OFS_FORCE_RESET: rdata_d = BYTE_ZERO;
      default:         rdata_d = BYTE_ZERO;
    endcase
  end

  // Breakpoint compare against the live address bus. The request is
  // registered, so it trails the matching bus cycle by one clock; the
  // break logic outside has to allow for that latency.
  // disabled breakpoint ignores everything
  assign bkpt_hit = BREAKPOINT_ENABLE && ADDR_VALID && (ADDR_BUS == bkpt_q);

  // The read data is captured before the FIFO shifts, so a low byte read
  // returns the word that was at the head when the read was issued.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rdata_q <= BYTE_ZERO;
    end
    else if (CPU_RD)
    begin
      rdata_q <= rdata_d;
    end
  end

  assign CPU_RDATA = rdata_q;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      arm_q <= 1'b0;
    end
    else
    begin
      arm_q <= arm_d;
    end
  end

  // Breakpoint register lives outside the memory map.
  // breakpoint address storage
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      bkpt_q <= BKPT_RESET;
    end
    else if (BKPT_CMD_WR)
    begin
      bkpt_q <= BKPT_CMD_WDATA;
    end
  end

  // The readback is held in its own register so the word stays put while the
  // host shifts it out, even if a write command follows.
  // serial breakpoint readback
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      bkpt_rdata_q <= BKPT_RESET;
    end
    else if (BKPT_CMD_RD)
    begin
      bkpt_rdata_q <= bkpt_q;
    end
  end

  assign BKPT_CMD_RDATA = bkpt_rdata_q;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      break_force_q <= 1'b0;
      break_tag_q   <= 1'b0;
    end
    else
    begin
      break_force_q <= bkpt_hit && FORCE_TAG_SELECT;
      break_tag_q   <= bkpt_hit && !FORCE_TAG_SELECT && OPCODE_FETCH;
    end
  end

  assign BREAK_FORCE_REQ = break_force_q;
  assign BREAK_TAG_REQ   = break_tag_q;

  // The force-reset bit is a one-cycle request; nothing is stored, which
  // is why the byte reads back as zero.
  // serial one forces MCU reset
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      force_reset_q <= 1'b0;
    end
    else
    begin
      force_reset_q <= ser_hits_reset && SER_WDATA[FORCE_RESET_BIT];
    end
  end

  assign FORCE_RESET = force_reset_q;

endmodule : debug_breakpoint_fifo_regs

// File: dbg_regs_props.sv
`timescale 1ns/1ps
module dbg_regs_props
  import dbg_pkg::*;
(
  // Clock and reset
  input wire logic              CLK,
  input wire logic              RST_N,
  // Serial host side
  input wire logic              SER_WR,
  input wire logic [ADDR_W-1:0] SER_ADDR,
  input wire logic [BYTE_W-1:0] SER_WDATA,
  input wire logic              FORCE_RESET,
  input wire logic              BKPT_CMD_WR,
  input wire logic [WORD_W-1:0] BKPT_CMD_WDATA,
  // Breakpoint match
  input wire logic              BREAKPOINT_ENABLE,
  input wire logic              FORCE_TAG_SELECT,
  input wire logic              ADDR_VALID,
  input wire logic              OPCODE_FETCH,
  input wire logic [WORD_W-1:0] ADDR_BUS,
  input wire logic              BREAK_FORCE_REQ,
  input wire logic              BREAK_TAG_REQ,
  // Arm control and comparator
  input wire logic              CTRL_WR,
  input wire logic              CTRL_WDATA_ENABLE,
  input wire logic              CTRL_WDATA_ARM,
  input wire logic              RUN_DONE,
  input wire logic              ARMED,
  input wire logic [WORD_W-1:0] COMPARE_A
);
  logic [WORD_W-1:0] bkpt_q;
  logic              hit;
  logic              ser_force;
  logic              disarm;
  default clocking dcb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // The shadow follows serial commands only, so a CPU path into it shows up as a wrong break.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      bkpt_q <= BKPT_RESET;
    else if (BKPT_CMD_WR)
      bkpt_q <= BKPT_CMD_WDATA;
  end
  assign hit       = ADDR_VALID && BREAKPOINT_ENABLE && (ADDR_BUS == bkpt_q);
  assign ser_force = SER_WR && (SER_ADDR == OFS_FORCE_RESET) && SER_WDATA[FORCE_RESET_BIT];
  assign disarm    = (CTRL_WR && !(CTRL_WDATA_ENABLE && CTRL_WDATA_ARM)) || (RUN_DONE && !CTRL_WR);
  a_force_pulse: assert property (ser_force |=> FORCE_RESET) else $error("no reset pulse");
  a_force_cause: assert property (FORCE_RESET |-> $past(ser_force)) else $error("stray reset");
  a_cmp_locked: assert property (ARMED |=> $stable(COMPARE_A)) else $error("compare moved");
  a_arm_set: assert property (CTRL_WR && CTRL_WDATA_ENABLE && CTRL_WDATA_ARM |=> ARMED) else $error("no arm");
  a_arm_clear: assert property (disarm |=> !ARMED) else $error("still armed");
  a_break_force: assert property (hit && FORCE_TAG_SELECT |=> BREAK_FORCE_REQ && !BREAK_TAG_REQ) else $error("force");
  a_break_tag: assert property (hit && !FORCE_TAG_SELECT && OPCODE_FETCH |=> BREAK_TAG_REQ) else $error("tag");
  a_break_off: assert property (!BREAKPOINT_ENABLE |=> !BREAK_FORCE_REQ && !BREAK_TAG_REQ) else $error("break");
endmodule : dbg_regs_props

// File: dbg_host_model.sv
`timescale 1ns/1ps
module dbg_host_model
  import dbg_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Serial writes and breakpoint commands
  output logic                   ser_wr = 1'b0,
  output logic      [ADDR_W-1:0] ser_addr = 4'h0,
  output logic      [BYTE_W-1:0] ser_wdata = 8'h00,
  output logic                   bkpt_rd = 1'b0,
  output logic                   bkpt_wr = 1'b0,
  output logic      [WORD_W-1:0] bkpt_wdata = 16'h0000,
  input  wire logic [WORD_W-1:0] bkpt_rdata
);
  task automatic ser_write(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] d);
    @(posedge clk);
    ser_wr    <= 1'b1;
    ser_addr  <= a;
    ser_wdata <= d;
    @(posedge clk);
    ser_wr    <= 1'b0;
    // Released data is inverted so that a late sample cannot match by luck.
    ser_wdata <= ~d;
    #1;
  endtask : ser_write
  task automatic bkpt_write(input logic [WORD_W-1:0] d);
    @(posedge clk);
    bkpt_wr    <= 1'b1;
    bkpt_wdata <= d;
    @(posedge clk);
    bkpt_wr    <= 1'b0;
    bkpt_wdata <= ~d;
    #1;
  endtask : bkpt_write
  task automatic bkpt_read(output logic [WORD_W-1:0] q);
    @(posedge clk);
    bkpt_rd <= 1'b1;
    @(posedge clk);
    bkpt_rd <= 1'b0;
    #1;
    q = bkpt_rdata;
  endtask : bkpt_read
endmodule : dbg_host_model

// File: debug_breakpoint_fifo_regs_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; $display("FAIL %0t value mismatch: got %h, expected %h", $time, a, b); end end
module debug_breakpoint_fifo_regs_tb
  import dbg_pkg::*;
;
  logic              CLK = 1'b0, RST_N = 1'b0, CPU_RD = 1'b0, CPU_WR = 1'b0, CTRL_WR = 1'b0, RUN_DONE = 1'b0;
  logic              CTRL_WDATA_ENABLE = 1'b0, CTRL_WDATA_ARM = 1'b0, EVENT_ONLY = 1'b0, TRACE_PUSH = 1'b0;
  logic              BREAKPOINT_ENABLE = 1'b0, FORCE_TAG_SELECT = 1'b0, ADDR_VALID = 1'b0, OPCODE_FETCH = 1'b0;
  logic              SER_WR, FORCE_RESET, BKPT_CMD_RD, BKPT_CMD_WR, BREAK_FORCE_REQ, BREAK_TAG_REQ, ARMED;
  logic [ADDR_W-1:0] CPU_ADDR = 4'h0, SER_ADDR;
  logic [BYTE_W-1:0] CPU_WDATA = 8'h00, CPU_RDATA, SER_WDATA;
  logic [WORD_W-1:0] ADDR_BUS = 16'h0000, LAST_OPCODE_ADDR = 16'h0000, TRACE_DATA = 16'h0000;
  logic [WORD_W-1:0] BKPT_CMD_WDATA, BKPT_CMD_RDATA, COMPARE_A, COMPARE_B, q16, e16;
  logic [BYTE_W-1:0] pat [4] = '{8'h5a, 8'hc3, 8'h81, 8'h7e};
  int                num_errors = 0, checks = 0, pulses = 0;
  debug_breakpoint_fifo_regs debug_breakpoint_fifo_regs_inst (
    .CLK, .RST_N, .CPU_RD, .CPU_WR, .CPU_ADDR, .CPU_WDATA, .CPU_RDATA, .SER_WR, .SER_ADDR, .SER_WDATA,
    .FORCE_RESET, .BKPT_CMD_RD, .BKPT_CMD_WR, .BKPT_CMD_WDATA, .BKPT_CMD_RDATA, .BREAKPOINT_ENABLE,
    .FORCE_TAG_SELECT, .ADDR_VALID, .OPCODE_FETCH, .ADDR_BUS, .LAST_OPCODE_ADDR, .BREAK_FORCE_REQ,
    .BREAK_TAG_REQ, .CTRL_WR, .CTRL_WDATA_ENABLE, .CTRL_WDATA_ARM, .RUN_DONE, .ARMED, .EVENT_ONLY,
    .TRACE_PUSH, .TRACE_DATA, .COMPARE_A, .COMPARE_B);
  dbg_host_model dbg_host_model_inst (.clk(CLK), .ser_wr(SER_WR), .ser_addr(SER_ADDR), .ser_wdata(SER_WDATA),
    .bkpt_rd(BKPT_CMD_RD), .bkpt_wr(BKPT_CMD_WR), .bkpt_wdata(BKPT_CMD_WDATA), .bkpt_rdata(BKPT_CMD_RDATA));
  always #10 CLK = ~CLK;
  always @(posedge CLK)
    if (FORCE_RESET === 1'b1)
      pulses++;
  // One CPU bus cycle; on a read, d is the expected byte.
  task automatic cpu_access(input logic wr, input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] d);
    @(posedge CLK);
    CPU_WR    <= wr;
    CPU_RD    <= ~wr;
    CPU_ADDR  <= a;
    CPU_WDATA <= d;
    @(posedge CLK);
    CPU_WR    <= 1'b0;
    CPU_RD    <= 1'b0;
    #1;
    if (!wr)
      `CHK(CPU_RDATA, d)
  endtask : cpu_access
  // Pulses the control write, or the end-of-run strobe when done is set.
  task automatic ctl(input logic en, input logic arm, input logic done);
    @(posedge CLK);
    CTRL_WR           <= ~done;
    RUN_DONE          <= done;
    CTRL_WDATA_ENABLE <= en;
    CTRL_WDATA_ARM    <= arm;
    @(posedge CLK);
    CTRL_WR  <= 1'b0;
    RUN_DONE <= 1'b0;
    #1;
  endtask : ctl
  task automatic close_out();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if ((num_errors == 0) && (checks > 0))
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (5000) @(posedge CLK);
    num_errors++;
    close_out();
  end
  initial
  begin
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    for (int i = 0; i < 4; i++)
      cpu_access(1'b0, 4'(i), CMP_RESET);
    cpu_access(1'b0, 4'h6, BYTE_ZERO);
    for (int i = 0; i < 4; i++)
      cpu_access(1'b1, 4'(i), pat[i]);
    for (int i = 0; i < 4; i++)
      cpu_access(1'b0, 4'(i), pat[i]);
    `CHK(COMPARE_B, {pat[2], pat[3]})
    $display("test comparators done");
    ctl(1'b1, 1'b1, 1'b0);
    `CHK(ARMED, 1'b1)
    cpu_access(1'b1, OFS_CMP_A_HIGH, 8'h00);
    dbg_host_model_inst.ser_write(OFS_CMP_A_LOW, 8'hff);
    `CHK(COMPARE_A, {pat[0], pat[1]})
    ctl(1'b1, 1'b1, 1'b1);
    `CHK(ARMED, 1'b0)
    ctl(1'b1, 1'b1, 1'b0);
    ctl(1'b0, 1'b1, 1'b0);
    `CHK(ARMED, 1'b0)
    $display("test arm done");
    cpu_access(1'b1, OFS_FORCE_RESET, 8'h01);
    dbg_host_model_inst.ser_write(OFS_FORCE_RESET, 8'hfe);
    dbg_host_model_inst.ser_write(OFS_FORCE_RESET, 8'h01);
    repeat (2) @(posedge CLK);
    #1;
    `CHK(pulses, 1)
    cpu_access(1'b0, OFS_FORCE_RESET, BYTE_ZERO);
    $display("test force reset done");
    dbg_host_model_inst.bkpt_write(16'hbeef);
    dbg_host_model_inst.bkpt_read(q16);
    `CHK(q16, 16'hbeef)
    for (int m = 0; m < 4; m++)
    begin
      @(posedge CLK);
      BREAKPOINT_ENABLE <= m[1];
      FORCE_TAG_SELECT  <= m[0];
      {ADDR_VALID, OPCODE_FETCH, ADDR_BUS} <= {2'b11, 16'hbeef};
      @(posedge CLK);
      ADDR_VALID <= 1'b0;
      #1;
      `CHK({BREAK_FORCE_REQ, BREAK_TAG_REQ}, {m[1] & m[0], m[1] & ~m[0]})
    end
    $display("test breakpoint done");
    for (int i = 0; i < 12; i++)
    begin
      @(posedge CLK);
      LAST_OPCODE_ADDR <= 16'(16'h1234 + i * 16'h0101);
      e16 = (i < 8) ? WORD_ZERO : 16'(16'h1234 + (i - 8) * 16'h0101);
      cpu_access(1'b0, OFS_FIFO_HIGH, e16[15:8]);
      cpu_access(1'b0, OFS_FIFO_LOW, e16[7:0]);
    end
    $display("test profiling done");
    ctl(1'b1, 1'b1, 1'b0);
    for (int k = 0; k < 8; k++)
    begin
      @(posedge CLK);
      TRACE_PUSH <= 1'b1;
      TRACE_DATA <= 16'(16'hab40 + k);
      EVENT_ONLY <= 1'b1;
    end
    @(posedge CLK);
    TRACE_PUSH <= 1'b0;
    cpu_access(1'b0, OFS_FIFO_HIGH, BYTE_ZERO);
    cpu_access(1'b0, OFS_FIFO_LOW, 8'h40);
    cpu_access(1'b0, OFS_FIFO_LOW, 8'h40);
    ctl(1'b0, 1'b0, 1'b0);
    cpu_access(1'b0, OFS_FIFO_LOW, 8'h40);
    cpu_access(1'b0, OFS_FIFO_LOW, 8'h41);
    $display("test trace done");
    @(posedge CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    for (int i = 0; i < 6; i++)
      cpu_access(1'b0, 4'(i), BYTE_ZERO);
    dbg_host_model_inst.bkpt_read(q16);
    `CHK(q16, WORD_ZERO)
    `CHK(ARMED, 1'b0)
    $display("test reset done");
    close_out();
  end
endmodule : debug_breakpoint_fifo_regs_tb
bind debug_breakpoint_fifo_regs dbg_regs_props dbg_regs_props_inst (
  .CLK, .RST_N, .SER_WR, .SER_ADDR, .SER_WDATA, .FORCE_RESET, .BKPT_CMD_WR, .BKPT_CMD_WDATA,
  .BREAKPOINT_ENABLE, .FORCE_TAG_SELECT, .ADDR_VALID, .OPCODE_FETCH, .ADDR_BUS, .BREAK_FORCE_REQ,
  .BREAK_TAG_REQ, .CTRL_WR, .CTRL_WDATA_ENABLE, .CTRL_WDATA_ARM, .RUN_DONE, .ARMED, .COMPARE_A);
